// *** inc/osc_sel_params.svh ***
`ifndef OSC_SEL_PARAMS_SVH
`define OSC_SEL_PARAMS_SVH

// group field codes
`define GRP_PRI_PLL    3'h7
`define GRP_PRI        3'h3
`define GRP_SEC        3'h0
`define GRP_FRC        3'h1
`define GRP_SLOW_RC    3'h2

// primary choice codes
`define PRI_EXTERNAL_CLOCK_IO_MODE_PLL4  5'h0d
`define PRI_EXTERNAL_CLOCK_IO_MODE_PLL8  5'h0e
`define PRI_EXTERNAL_CLOCK_IO_MODE_PLL16 5'h0f
`define PRI_FRC_PLL4   5'h01
`define PRI_FRC_PLL8   5'h0a
`define PRI_FRC_PLL16  5'h03
`define PRI_XT_PLL4    5'h05
`define PRI_XT_PLL8    5'h06
`define PRI_XT_PLL16   5'h07
`define PRI_HS2_PLL4   5'h11
`define PRI_HS2_PLL8   5'h12
`define PRI_HS2_PLL16  5'h13
`define PRI_HS3_PLL4   5'h15
`define PRI_HS3_PLL8   5'h16
`define PRI_HS3_PLL16  5'h17
`define PRI_EXTERNAL_CLOCK_IO_MODE       5'h0c
`define PRI_XT         5'h04
`define PRI_HS         5'h02
`define PRI_EC         5'h0b
`define PRI_ERC        5'h09
`define PRI_EXTERNAL_RC_IO_MODE      5'h08
`define PRI_XTL        5'h00

// start-up count and trim
`define STARTUP_CYCLES 1024
`define STARTUP_WIDTH  10
`define TRIM_RESET     4'h0
`define TRIM_WIDTH     4

// register addresses
`define ADDR_CONTROL   4'h0
`define ADDR_TRIM      4'h1
`define ADDR_STATUS    4'h2

// control register field positions
`define CTL_SEC_EN_BIT 1
`define CTL_NEW_LO     8
`define CTL_NEW_HI     10
`define CTL_CUR_LO     12
`define CTL_CUR_HI     14
`define CTL_LOCK_BIT   5

// status register bit positions
`define STS_RELEASE_BIT 0
`define STS_SW_EN_BIT   1
`define STS_DONE_BIT    2
`define STS_VALID_BIT   3

`endif

// *** inc/osc_sel_pkg.sv ***
package osc_sel_pkg;
  typedef enum logic [1:0] {
    SRC_PRIMARY,
    SRC_SECONDARY,
    SRC_FAST_RC,
    SRC_SLOW_RC
  } source_t;

  typedef enum logic [1:0] {
    MULT_NONE,
    MULT_X4,
    MULT_X8,
    MULT_X16
  } mult_t;

  typedef enum logic [1:0] {
    PIN_CRYSTAL,
    PIN_IO,
    PIN_CLKOUT
  } pin2_t;

  typedef enum logic [1:0] {
    PRI_EXT_CLOCK,
    PRI_CRYSTAL,
    PRI_RC_NET,
    PRI_FAST_RC
  } pri_kind_t;
endpackage

// *** inc/osc_sel_if.sv ***
`timescale 1ns/1ps
interface osc_sel_if;
  logic [2:0]           group;
  logic [4:0]           choice;
  osc_sel_pkg::source_t source;
  osc_sel_pkg::mult_t   mult;
  osc_sel_pkg::pin2_t   pin2;
  logic                 needs_startup;
  logic                 valid;

  modport decoder (input group, input choice,
                   output source, output mult, output pin2,
                   output needs_startup, output valid);
  modport user (output group, output choice,
                input source, input mult, input pin2,
                input needs_startup, input valid);
endinterface

// *** src/osc_mode_decode.sv ***
`timescale 1ns/1ps
`include "osc_sel_params.svh"
module osc_mode_decode (
  osc_sel_if.decoder d
);
  function automatic osc_sel_pkg::mult_t pri_mult(input logic [4:0] c);
    case (c)
      `PRI_EXTERNAL_CLOCK_IO_MODE_PLL4, `PRI_FRC_PLL4, `PRI_XT_PLL4,
      `PRI_HS2_PLL4, `PRI_HS3_PLL4:    pri_mult = osc_sel_pkg::MULT_X4;
      `PRI_EXTERNAL_CLOCK_IO_MODE_PLL8, `PRI_FRC_PLL8, `PRI_XT_PLL8,
      `PRI_HS2_PLL8, `PRI_HS3_PLL8:    pri_mult = osc_sel_pkg::MULT_X8;
      `PRI_EXTERNAL_CLOCK_IO_MODE_PLL16, `PRI_FRC_PLL16, `PRI_XT_PLL16,
      `PRI_HS2_PLL16, `PRI_HS3_PLL16:  pri_mult = osc_sel_pkg::MULT_X16;
      default:                          pri_mult = osc_sel_pkg::MULT_NONE;
    endcase
  endfunction

  function automatic osc_sel_pkg::pri_kind_t pri_kind(input logic [4:0] c);
    case (c)
      `PRI_FRC_PLL4, `PRI_FRC_PLL8, `PRI_FRC_PLL16:
        pri_kind = osc_sel_pkg::PRI_FAST_RC;
      `PRI_EXTERNAL_CLOCK_IO_MODE_PLL4, `PRI_EXTERNAL_CLOCK_IO_MODE_PLL8, `PRI_EXTERNAL_CLOCK_IO_MODE_PLL16, `PRI_EXTERNAL_CLOCK_IO_MODE, `PRI_EC:
        pri_kind = osc_sel_pkg::PRI_EXT_CLOCK;
      `PRI_ERC, `PRI_EXTERNAL_RC_IO_MODE:
        pri_kind = osc_sel_pkg::PRI_RC_NET;
      default:
        pri_kind = osc_sel_pkg::PRI_CRYSTAL;
    endcase
  endfunction

  logic valid_pll;
  logic valid_pri;

  always_comb begin
    valid_pll = pri_mult(d.choice) != osc_sel_pkg::MULT_NONE;
    valid_pri = (d.choice == `PRI_EXTERNAL_CLOCK_IO_MODE) || (d.choice == `PRI_XT) || (d.choice == `PRI_HS)
             || (d.choice == `PRI_EC) || (d.choice == `PRI_ERC)
             || (d.choice == `PRI_EXTERNAL_RC_IO_MODE) || (d.choice == `PRI_XTL);
    d.source        = osc_sel_pkg::SRC_PRIMARY;
    d.mult          = osc_sel_pkg::MULT_NONE;
    d.needs_startup = 1'b0;
    d.valid         = 1'b1;
    // second pin follows the primary choice regardless of group
    case (d.choice)
      `PRI_EC, `PRI_ERC:
        d.pin2 = osc_sel_pkg::PIN_CLKOUT;
      `PRI_EXTERNAL_CLOCK_IO_MODE, `PRI_EXTERNAL_RC_IO_MODE, `PRI_EXTERNAL_CLOCK_IO_MODE_PLL4, `PRI_EXTERNAL_CLOCK_IO_MODE_PLL8, `PRI_EXTERNAL_CLOCK_IO_MODE_PLL16,
      `PRI_FRC_PLL4, `PRI_FRC_PLL8, `PRI_FRC_PLL16:
        d.pin2 = osc_sel_pkg::PIN_IO;
      default:
        d.pin2 = osc_sel_pkg::PIN_CRYSTAL;
    endcase
    case (d.group)
      `GRP_PRI_PLL: begin
        d.mult          = pri_mult(d.choice);
        d.source        = (pri_kind(d.choice) == osc_sel_pkg::PRI_FAST_RC)
                        ? osc_sel_pkg::SRC_FAST_RC : osc_sel_pkg::SRC_PRIMARY;
        d.needs_startup = pri_kind(d.choice) == osc_sel_pkg::PRI_CRYSTAL;
        d.valid         = valid_pll;
      end
      `GRP_PRI: begin
        d.source        = osc_sel_pkg::SRC_PRIMARY;
        d.needs_startup = (d.choice == `PRI_XT) || (d.choice == `PRI_HS)
                       || (d.choice == `PRI_XTL);
        d.valid         = valid_pri;
      end
      `GRP_SEC: begin
        d.source        = osc_sel_pkg::SRC_SECONDARY;
        d.needs_startup = 1'b1;
      end
      `GRP_FRC:
        d.source = osc_sel_pkg::SRC_FAST_RC;
      `GRP_SLOW_RC:
        d.source = osc_sel_pkg::SRC_SLOW_RC;
      default:
        d.valid = 1'b0;
    endcase
  end
endmodule

// *** src/startup_timer.sv ***
`timescale 1ns/1ps
`include "osc_sel_params.svh"
module startup_timer #(
  parameter int WIDTH = `STARTUP_WIDTH
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // control
  input  wire logic restart,
  input  wire logic osc_tick,
  input  wire logic needed,
  // status
  output logic      done
);
  logic [WIDTH-1:0] count;
  logic             expired;
  logic [WIDTH-1:0] next_count;
  logic             next_expired;

  always_comb begin
    next_count   = count;
    next_expired = expired;
    if (restart) begin
      next_count   = '0;
      next_expired = 1'b0;
    end else if (!expired && osc_tick) begin
      next_count = count + 1'b1;
      // wrap of the full-width counter marks 1024 cycles
      if (count == {WIDTH{1'b1}})
        next_expired = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end

  assign done = expired || !needed;
endmodule

// *** src/osc_source_select.sv ***
`timescale 1ns/1ps
`include "osc_sel_params.svh"
module osc_source_select #(
  parameter int TRIM_W = `TRIM_WIDTH
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // configuration bits and restart events
  input  wire logic [2:0]        group_config_bits,
  input  wire logic [4:0]        primary_choice_bits,
  input  wire logic [1:0]        switch_monitor_config,
  input  wire logic              por_bor_event,
  input  wire logic              sleep_wake,
  input  wire logic              sleep_active,
  // oscillator side
  input  wire logic              osc_tick,
  input  wire logic              pll_locked,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic [15:0]            reg_rdata,
  // clock control outputs
  output logic                   clock_release,
  output osc_sel_pkg::source_t   sys_source,
  output osc_sel_pkg::mult_t     pll_mult,
  output logic                   pll_enable,
  output osc_sel_pkg::pin2_t     second_osc_pin_function,
  output logic                   secondary_osc_run,
  output logic                   fast_rc_run,
  output logic [TRIM_W-1:0]      rc_trim_code,
  output logic                   switching_enabled,
  output logic                   config_valid
);
  osc_sel_if dec ();

  logic [2:0]        current_group_field;
  logic [2:0]        new_group_field;
  logic              secondary_osc_enable;
  logic [TRIM_W-1:0] trim;
  logic              lock;
  logic              restart;
  logic              startup_done;
  logic [15:0]       rdata;

  logic [2:0]        next_current;
  logic [2:0]        next_new;
  logic              next_sec_en;
  logic [TRIM_W-1:0] next_trim;
  logic              next_lock;
  logic [15:0]       next_rdata;
  logic [15:0]       control_word;
  logic [15:0]       status_word;
  logic [15:0]       trim_word;
  logic              wr_control;
  logic              wr_trim;
  logic              rd_control;
  logic              rd_trim;
  logic              rd_status;

  // restart of the oscillator: reset event or wake from sleep
  assign restart = por_bor_event || sleep_wake;

  assign dec.group  = current_group_field;
  assign dec.choice = primary_choice_bits;

  osc_mode_decode u_decode (
    .d (dec)
  );

  startup_timer #(
    .WIDTH (`STARTUP_WIDTH)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .restart  (restart),
    .osc_tick (osc_tick),
    .needed   (dec.needs_startup),
    .done     (startup_done)
  );

  function automatic logic [15:0] pack_control(input logic [2:0] cur,
                                                input logic [2:0] nxt,
                                                input logic       lk,
                                                input logic       sen);
    logic [15:0] w;
    w = 16'h0000;
    w[`CTL_CUR_HI:`CTL_CUR_LO] = cur;
    w[`CTL_NEW_HI:`CTL_NEW_LO] = nxt;
    w[`CTL_LOCK_BIT]           = lk;
    w[`CTL_SEC_EN_BIT]         = sen;
    pack_control = w;
  endfunction

  assign control_word = pack_control(current_group_field, new_group_field, lock,
                                     secondary_osc_enable);

  // switching is fused off when the top config bit is set
  assign switching_enabled = !switch_monitor_config[1];

  function automatic logic addr_hit(input logic [3:0] a,
                                    input logic [3:0] target,
                                    input logic       strobe);
    addr_hit = strobe && (a == target);
  endfunction

  function automatic logic [15:0] pack_status(input logic valid,
                                               input logic done,
                                               input logic sw_en,
                                               input logic rel);
    logic [15:0] w;
    w                   = 16'h0000;
    w[`STS_VALID_BIT]   = valid;
    w[`STS_DONE_BIT]    = done;
    w[`STS_SW_EN_BIT]   = sw_en;
    w[`STS_RELEASE_BIT] = rel;
    pack_status = w;
  endfunction

  // address decode shared by the write and read paths
  assign wr_control = addr_hit(reg_addr, `ADDR_CONTROL, reg_write);
  assign wr_trim    = addr_hit(reg_addr, `ADDR_TRIM, reg_write);
  assign rd_control = addr_hit(reg_addr, `ADDR_CONTROL, reg_read);
  assign rd_trim    = addr_hit(reg_addr, `ADDR_TRIM, reg_read);
  assign rd_status  = addr_hit(reg_addr, `ADDR_STATUS, reg_read);

  assign trim_word   = {{(16-TRIM_W){1'b0}}, trim};
  assign status_word = pack_status(config_valid, startup_done, switching_enabled,
                                   clock_release);

  // current and new group fields
  always_comb begin
    next_current = current_group_field;
    next_new     = new_group_field;
    if (por_bor_event) begin
      next_current = group_config_bits;
      next_new     = group_config_bits;
    end else begin
      if (!switching_enabled) begin
        // config bits steer selection through the current field, which reloads them every cycle
        next_current = group_config_bits;
      end
      // new group only stored; runtime switching is outside this block
      if (wr_control && switching_enabled) begin
        next_new = reg_wdata[`CTL_NEW_HI:`CTL_NEW_LO];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      current_group_field <= `GRP_FRC;
      new_group_field     <= `GRP_FRC;
    end else begin
      current_group_field <= next_current;
      new_group_field     <= next_new;
    end
  end

  // secondary oscillator enable, software owned
  always_comb begin
    next_sec_en = secondary_osc_enable;
    if (wr_control) begin
      next_sec_en = reg_wdata[`CTL_SEC_EN_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      secondary_osc_enable <= 1'b0;
    end else begin
      secondary_osc_enable <= next_sec_en;
    end
  end

  // fast rc trim code, software owned
  always_comb begin
    next_trim = trim;
    if (wr_trim) begin
      next_trim = reg_wdata[TRIM_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trim <= TRIM_W'(`TRIM_RESET);
    end else begin
      trim <= next_trim;
    end
  end

  // lock is registered so a read never catches a half-settled level
  always_comb begin
    next_lock = 1'b0;
    if (pll_enable) begin
      next_lock = pll_locked;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lock <= 1'b0;
    end else begin
      lock <= next_lock;
    end
  end

  // read data stand for exactly one cycle after the read strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (rd_control) begin
      next_rdata = control_word;
    end else if (rd_trim) begin
      next_rdata = trim_word;
    end else if (rd_status) begin
      next_rdata = status_word;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata    = rdata;
  assign rc_trim_code = trim;

  // secondary source without its enable is not a usable system clock
  always_comb begin
    sys_source = dec.source;
    if (dec.source == osc_sel_pkg::SRC_SECONDARY && !secondary_osc_enable)
      sys_source = osc_sel_pkg::SRC_SLOW_RC;
  end

  assign config_valid            = dec.valid;
  assign pll_mult                = dec.mult;
  assign second_osc_pin_function = dec.pin2;

  // multiplier runs only when the decoder picked a gain
  always_comb begin
    pll_enable = 1'b0;
    if (dec.mult != osc_sel_pkg::MULT_NONE) begin
      pll_enable = 1'b1;
    end
  end

  // enable keeps it running through sleep as well
  always_comb begin
    secondary_osc_run = 1'b0;
    if (secondary_osc_enable) begin
      secondary_osc_run = 1'b1;
    end else if (current_group_field == `GRP_SEC && !sleep_active) begin
      secondary_osc_run = 1'b1;
    end
  end

  always_comb begin
    fast_rc_run = 1'b0;
    if (dec.source == osc_sel_pkg::SRC_FAST_RC) begin
      fast_rc_run = 1'b1;
    end
  end

  // release waits for a settled restart, and for the start-up count only in modes that need one
  always_comb begin
    clock_release = 1'b0;
    if (startup_done && !restart) begin
      clock_release = 1'b1;
    end
  end
endmodule

// *** test/osc_source_select_sva.sv ***
`timescale 1ns/1ps
module osc_source_select_sva (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 rstn,
  // configuration and restarts
  input wire logic [2:0]           group_config_bits,
  input wire logic [4:0]           primary_choice_bits,
  input wire logic [1:0]           switch_monitor_config,
  input wire logic                 por_bor_event,
  input wire logic                 sleep_wake,
  input wire logic                 osc_tick,
  input wire logic                 pll_locked,
  // register port
  input wire logic [3:0]           reg_addr,
  input wire logic                 reg_read,
  input wire logic [15:0]          reg_rdata,
  // outputs
  input wire logic                 clock_release,
  input osc_sel_pkg::source_t      sys_source,
  input osc_sel_pkg::mult_t        pll_mult,
  input wire logic                 pll_enable,
  input osc_sel_pkg::pin2_t        second_osc_pin_function,
  input wire logic                 secondary_osc_run,
  input wire logic                 fast_rc_run,
  input wire logic                 switching_enabled
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [10:0] tick_cnt;
  logic [10:0] next_tick_cnt;
  logic        crys;
  // only valid once a restart has loaded the config, hence the saturated reset value
  assign crys = (group_config_bits == 3'h0) || (group_config_bits == 3'h3 &&
                (primary_choice_bits == 5'h00 || primary_choice_bits == 5'h04 ||
                 primary_choice_bits == 5'h02));
  always_comb begin
    next_tick_cnt = tick_cnt;
    if (por_bor_event || sleep_wake) begin
      next_tick_cnt = 11'h000;
    end else if (osc_tick && tick_cnt != 11'h400) begin
      next_tick_cnt = tick_cnt + 11'h001;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 11'h400;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end
  property p_lock; reg_read && reg_addr == 4'h0 |=> reg_rdata[5] == $past(pll_locked && pll_enable, 2); endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");
  property p_early; crys && tick_cnt < 11'h400 |-> !clock_release; endproperty
  a_early: assert property (p_early) else $error("clock released early");
  property p_late; crys && tick_cnt == 11'h3ff && osc_tick && !por_bor_event && !sleep_wake
    |=> ##[0:2] clock_release; endproperty
  a_late: assert property (p_late) else $error("clock not released");
  property p_restart; crys && (por_bor_event || sleep_wake) |=> !clock_release; endproperty
  a_restart: assert property (p_restart) else $error("restart kept release");
  property p_sec; sys_source == osc_sel_pkg::SRC_SECONDARY |-> secondary_osc_run; endproperty
  a_sec: assert property (p_sec) else $error("secondary not running");
  property p_frc; switch_monitor_config[1] && $stable(group_config_bits)
    && group_config_bits == 3'h1
    |-> fast_rc_run && sys_source == osc_sel_pkg::SRC_FAST_RC; endproperty
  a_frc: assert property (p_frc) else $error("fast rc not running");
  property p_mult; switch_monitor_config[1] && $stable(group_config_bits)
    && group_config_bits != 3'h7
    |-> !pll_enable && pll_mult == osc_sel_pkg::MULT_NONE; endproperty
  a_mult: assert property (p_mult) else $error("multiplier enable mismatch");
  property p_pin; primary_choice_bits == 5'h0b || primary_choice_bits == 5'h09
    |-> second_osc_pin_function == osc_sel_pkg::PIN_CLKOUT; endproperty
  a_pin: assert property (p_pin) else $error("pin not clock output");
  property p_sw; switch_monitor_config[1] |-> !switching_enabled; endproperty
  a_sw: assert property (p_sw) else $error("switching not disabled");
endmodule
bind osc_source_select osc_source_select_sva i_sva (.core_clk, .rstn, .group_config_bits,
  .primary_choice_bits, .switch_monitor_config, .por_bor_event, .sleep_wake, .osc_tick,
  .pll_locked, .reg_addr, .reg_read, .reg_rdata, .clock_release, .sys_source, .pll_mult,
  .pll_enable, .second_osc_pin_function, .secondary_osc_run, .fast_rc_run, .switching_enabled);

// *** test/osc_source_model.sv ***
`timescale 1ns/1ps
module osc_source_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // requests
  input wire logic run,
  input wire logic lock_req,
  // oscillator side
  output logic     osc_tick,
  output logic     pll_locked
);
  logic [1:0] lock_dly;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      osc_tick <= 1'b0;
      lock_dly <= 2'h0;
    end else begin
      // the oscillator runs slower than the core, one tick every other cycle
      osc_tick <= run && !osc_tick;
      lock_dly <= {lock_dly[0], lock_req};
    end
  end
  assign pll_locked = lock_dly[1];
endmodule

// *** test/tb_oscillator_source_select.sv ***
`timescale 1ns/1ps
module tb_oscillator_source_select;
  logic core_clk = 1'b0, rstn = 1'b0, por_bor_event = 1'b0, sleep_wake = 1'b0;
  logic sleep_active = 1'b0, reg_write = 1'b0, reg_read = 1'b0, run = 1'b1, lock_req = 1'b0;
  logic [2:0] group_config_bits = 3'h1;
  logic [4:0] primary_choice_bits = 5'h00;
  logic [1:0] switch_monitor_config = 2'h2;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic osc_tick, pll_locked, clock_release, pll_enable, secondary_osc_run, fast_rc_run;
  logic switching_enabled, config_valid;
  logic [3:0] rc_trim_code;
  osc_sel_pkg::source_t sys_source;
  osc_sel_pkg::mult_t pll_mult;
  osc_sel_pkg::pin2_t second_osc_pin_function;
  int errors = 0, check_count = 0;
  always #5 core_clk = ~core_clk;
  osc_source_model i_osc (.core_clk, .rstn, .run, .lock_req, .osc_tick, .pll_locked);
  osc_source_select i_dut (.core_clk, .rstn, .group_config_bits, .primary_choice_bits,
    .switch_monitor_config, .por_bor_event, .sleep_wake, .sleep_active, .osc_tick, .pll_locked,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .clock_release, .sys_source,
    .pll_mult, .pll_enable, .second_osc_pin_function, .secondary_osc_run, .fast_rc_run,
    .rc_trim_code, .switching_enabled, .config_valid);
  task automatic results();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a; reg_wdata <= v; reg_write <= 1'b1;
    @(posedge core_clk); reg_write <= 1'b0;
  endtask
  // read data stand for one cycle only, so they are taken just after the answering edge
  task automatic rd(input logic [3:0] a);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge core_clk); reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic boot(input logic [2:0] g, input logic [4:0] c, input logic wake);
    group_config_bits <= g; primary_choice_bits <= c;
    if (wake) sleep_wake <= 1'b1;
    else por_bor_event <= 1'b1;
    @(posedge core_clk); por_bor_event <= 1'b0; sleep_wake <= 1'b0;
    @(posedge core_clk); #1;
  endtask
  // codes: source 0 pri 1 sec 2 fast 3 slow; mult 0 none..3 x16; pin 0 xtal 1 io 2 clkout
  task automatic mode(input logic [2:0] g, input logic [4:0] c, input logic [1:0] s,
                      input logic [1:0] m, input logic [1:0] p);
    boot(g, c, 1'b0);
    chk(16'(sys_source), 16'(s));
    chk(16'(pll_mult), 16'(m));
    chk(16'(second_osc_pin_function), 16'(p));
    chk(16'(pll_enable), 16'(m != 2'h0));
    if (s == 2'h2) chk(16'(fast_rc_run), 16'h0001);
    chk(16'(config_valid), 16'h0001);
    @(posedge core_clk);
    rd(4'h0);
    chk(16'(d[14:12]), 16'(g));
  endtask
  task automatic t_modes();
    mode(3'h7, 5'h01, 2'h2, 2'h1, 2'h1);
    mode(3'h7, 5'h0a, 2'h2, 2'h2, 2'h1);
    mode(3'h7, 5'h03, 2'h2, 2'h3, 2'h1);
    mode(3'h7, 5'h05, 2'h0, 2'h1, 2'h0);
    mode(3'h3, 5'h0b, 2'h0, 2'h0, 2'h2);
    mode(3'h3, 5'h08, 2'h0, 2'h0, 2'h1);
    mode(3'h1, 5'h0c, 2'h2, 2'h0, 2'h1);
    mode(3'h2, 5'h00, 2'h3, 2'h0, 2'h0);
    mode(3'h0, 5'h00, 2'h3, 2'h0, 2'h0);
  endtask
  task automatic t_secondary();
    wr(4'h0, 16'h0702);
    #1 chk(16'(sys_source), 16'h0001);
    @(posedge core_clk); sleep_active <= 1'b1;
    @(posedge core_clk); #1 chk(16'(secondary_osc_run), 16'h0001);
    @(posedge core_clk);
    rd(4'h0);
    chk(16'(d[10:8]), 16'h0000);
    wr(4'h0, 16'h0000);
    #1 chk(16'(secondary_osc_run), 16'h0000);
    @(posedge core_clk); sleep_active <= 1'b0;
  endtask
  task automatic t_startup();
    int n;
    for (int k = 0; k < 2; k++) begin
      boot(3'h3, 5'h04, k[0]);
      n = 0;
      while (n < 1020) begin
        @(posedge core_clk);
        if (osc_tick === 1'b1) n++;
      end
      #1 chk(16'(clock_release), 16'h0000);
      repeat (12) @(posedge core_clk);
      #1 chk(16'(clock_release), 16'h0001);
    end
    boot(3'h3, 5'h0c, 1'b0);
    chk(16'(clock_release), 16'h0001);
    @(posedge core_clk);
  endtask
  task automatic t_regs();
    rd(4'h1);
    chk(d, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      wr(4'h1, 16'(k * 4'h8 - 1));
      rd(4'h1);
      chk(d, 16'(4'(k * 4'h8 - 1)));
      chk(16'(rc_trim_code), 16'(4'(k * 4'h8 - 1)));
    end
    wr(4'hf, 16'hffff);
    rd(4'hf);
    chk(d, 16'h0000);
    wr(4'h1, 16'h0000);
    boot(3'h7, 5'h03, 1'b0);
    @(posedge core_clk); lock_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(4'h0);
    chk(16'(d[5]), 16'h0001);
    lock_req <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(4'h0);
    chk(16'(d[5]), 16'h0000);
  endtask
  task automatic t_switch();
    switch_monitor_config <= 2'h0;
    boot(3'h1, 5'h0c, 1'b0);
    chk(16'(switching_enabled), 16'h0001);
    @(posedge core_clk);
    group_config_bits <= 3'h3;
    wr(4'h0, 16'h0200);
    rd(4'h0);
    chk(d, 16'h1200);
    chk(16'(sys_source), 16'h0002);
    rd(4'h2);
    chk(d, 16'h000f);
    boot(3'h4, 5'h0c, 1'b0);
    chk(16'(config_valid), 16'h0000);
    @(posedge core_clk);
    rd(4'h2);
    chk(d, 16'h0007);
    switch_monitor_config <= 2'h2;
    boot(3'h1, 5'h00, 1'b0);
    chk(16'(switching_enabled), 16'h0000);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_modes();
    t_secondary();
    t_startup();
    t_regs();
    t_switch();
    results();
  end
  initial begin
    #500us;
    errors++;
    results();
  end
endmodule
